/* rtl/usd_usart.sv */
// Chosen here: the address map and the APB slave port.
`timescale 1ns/1ps
module usd_usart
    import usd_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Interrupt handshake with the core
    input  wire logic        globalIrqEnable,
    input  wire logic        txDoneAck,
    output logic             txEmptyIrq,
    output logic             txCompleteIrq,
    output logic             rxCompleteIrq,
    // Serial pins
    output logic             serialOut,
    output logic             serialOutEn,
    input  wire logic        serialIn,
    input  wire logic        serialClockIn,
    output logic             serialClockOut,
    output logic             serialClockEn,
    output logic             serialInTaken
);

    logic [7:0]    statA_q, statB_q, frame_q;
    logic [11:0]   baud_q;
    logic [8:0]    txBuf_q;
    logic          txFull_q;
    logic          txDone_q;
    logic [8:0]    rxBuf_q;
    logic          rxFull_q;
    usd_fmt_t      fmt;
    usd_tx_state_t txState_q;
    usd_rx_state_t rxState_q;

    wire logic [2:0] cSize = {statB_q[BIT_CSZ2], frame_q[BIT_CSZ1],
                              frame_q[BIT_CSZ0]};
    wire logic transmit_enable_bit = statB_q[BIT_TX_ON];
    wire logic receive_enable_bit = statB_q[BIT_RX_ON];

    always_comb begin
        fmt.sync   = frame_q[BIT_SYNC];
        fmt.parEn  = frame_q[BIT_PEN];
        fmt.parOdd = frame_q[BIT_PODD];
        fmt.stop2  = frame_q[BIT_STOP2];
        fmt.cpol   = frame_q[BIT_CPOL];
        fmt.nBits  = (cSize == CSZ_NINE) ? 4'h9
                   : (cSize[2] ? 4'h8 : 4'(5 + cSize[1:0]));
    end

    // APB: zero wait states, error on unmapped address
    wire logic acc    = psel && penable;
    wire logic mapped = paddr inside {ADDR_DATA, ADDR_STAT_A, ADDR_STAT_B,
                                      ADDR_FRAME, ADDR_BAUD};
    wire logic wr     = acc && pwrite && mapped;
    wire logic rd     = acc && !pwrite && mapped;
    wire logic wrData = wr && paddr == ADDR_DATA;
    wire logic rdData = rd && paddr == ADDR_DATA;
    assign pready  = 1'b1;
    assign pslverr = acc && !mapped;

    // Three-stage input synchronisers
    logic [2:0] rxSync_q, ckSync_q;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rxSync_q <= 3'h7;
            ckSync_q <= 3'h0;
        end else begin
            rxSync_q <= {rxSync_q[1:0], serialIn};
            ckSync_q <= {ckSync_q[1:0], serialClockIn};
        end
    end
    logic rxLine_q, ckLine_q;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rxLine_q <= 1'b1;
            ckLine_q <= 1'b0;
        end else begin
            if (rxSync_q[1] == rxSync_q[2]) rxLine_q <= rxSync_q[2];
            if (ckSync_q[1] == ckSync_q[2]) ckLine_q <= ckSync_q[2];
        end
    end

    // Baud divider: one tick per (divisor+1) clocks
    logic [11:0] baudCnt_q;
    wire logic   baudTick = (baudCnt_q == baud_q);
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) baudCnt_q <= 12'h000;
        else         baudCnt_q <= baudTick ? 12'h000 : baudCnt_q + 12'h001;
    end
    wire logic [4:0] osr = statA_q[BIT_DBL] ? OSR_DOUBLE : OSR_NORMAL;

    // Sync clock: always master; edges from pin, clock from divider
    logic ckPrev_q, ckOut_q;
    wire  logic master = 1'b1;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ckPrev_q <= 1'b0;
            ckOut_q  <= 1'b0;
        end else begin
            ckPrev_q <= ckLine_q;
            if (fmt.sync && baudTick) ckOut_q <= !ckOut_q;
        end
    end
    wire logic ckRise = !ckPrev_q && ckLine_q;
    wire logic ckFall = ckPrev_q && !ckLine_q;
    // Master drives its own clock; feedback through pin keeps both alike
    wire logic txChange = fmt.cpol ? ckFall : ckRise;
    wire logic rxSample = fmt.cpol ? ckRise : ckFall;
    assign serialClockOut = ckOut_q;
    assign serialClockEn  = fmt.sync && master && (transmit_enable_bit || receive_enable_bit);

    // Async transmit bit timing
    logic [4:0] txSub_q;
    wire  logic txBitTick = fmt.sync ? txChange
                          : (baudTick && txSub_q == osr - 5'h01);
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn)       txSub_q <= 5'h00;
        else if (baudTick) txSub_q <= (txSub_q == osr - 5'h01) ? 5'h00
                                                             : txSub_q + 5'h01;
    end

    // Transmitter
    logic [8:0] txShift_q;
    logic [3:0] txCnt_q;
    logic       txPar_q, txOut_q, txStop2_q;
    // Pending byte still goes out after disable, so no enable term
    wire  logic txLoad = txFull_q && txBitTick &&
                         (txState_q == TX_IDLE ||
                          (txState_q == TX_STOP && txStop2_q == fmt.stop2));
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            txState_q <= TX_IDLE;
            txShift_q <= 9'h000;
            txCnt_q   <= 4'h0;
            txPar_q   <= 1'b0;
            txOut_q   <= 1'b1;
            txStop2_q <= 1'b0;
        end else if (txBitTick) begin
            if (txLoad) begin
                txState_q <= TX_START;
                txShift_q <= txBuf_q;
                txCnt_q   <= 4'h0;
                txPar_q   <= fmt.parOdd;
                txOut_q   <= 1'b0;
            end else begin
                case (txState_q)
                    TX_IDLE: txOut_q <= 1'b1;
                    TX_START, TX_DATA: begin
                        if (txState_q == TX_DATA &&
                            txCnt_q == fmt.nBits) begin
                            txState_q <= fmt.parEn ? TX_PARITY : TX_STOP;
                            txOut_q   <= fmt.parEn ? txPar_q : 1'b1;
                            txStop2_q <= 1'b0;
                        end else begin
                            txState_q <= TX_DATA;
                            txOut_q   <= txShift_q[0];
                            txPar_q   <= txPar_q ^ txShift_q[0];
                            txShift_q <= {1'b0, txShift_q[8:1]};
                            txCnt_q   <= txCnt_q + 4'h1;
                        end
                    end
                    TX_PARITY: begin
                        txState_q <= TX_STOP;
                        txOut_q   <= 1'b1;
                        txStop2_q <= 1'b0;
                    end
                    TX_STOP: begin
                        if (txStop2_q == fmt.stop2) begin
                            txState_q <= TX_IDLE;
                            txOut_q   <= 1'b1;
                        end else begin
                            txStop2_q <= 1'b1;
                        end
                    end
                    default: txState_q <= TX_IDLE;
                endcase
            end
        end
    end

    wire logic frameDone = txBitTick && txState_q == TX_STOP &&
                           txStop2_q == fmt.stop2;
    // Output held while shifter busy or buffer pending
    wire logic txActive = transmit_enable_bit || txFull_q || txState_q != TX_IDLE;
    assign serialOut   = txOut_q;
    assign serialOutEn = txActive;

    // Transmit buffer with ninth bit; upper bits masked by size
    logic [7:0] txMask;
    always_comb begin
        txMask = 8'hFF >> (4'h8 - (fmt.nBits > 4'h8 ? 4'h8 : fmt.nBits));
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            txBuf_q  <= 9'h000;
            txFull_q <= 1'b0;
        end else if (wrData) begin
            txBuf_q  <= {(cSize == CSZ_NINE) && statB_q[BIT_TX_NINTH],
                         pwdata[7:0] & txMask};
            txFull_q <= 1'b1;
        end else if (txLoad) begin
            txFull_q <= 1'b0;
        end
    end

    // Complete flag: set wins over any clear
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) txDone_q <= 1'b0;
        else if (frameDone && !txLoad && !txFull_q) txDone_q <= 1'b1;
        else if (txDoneAck ||
                 (wr && paddr == ADDR_STAT_A && pwdata[BIT_TX_DONE]))
            txDone_q <= 1'b0;
    end

    // Receiver timing
    logic [4:0] rxSub_q;
    logic [3:0] rxCnt_q;
    // Ten bits: nine data bits plus parity must all fit
    logic [9:0] rxShift_q;
    wire  logic [4:0] half = osr >> 1;
    wire  logic rxMid = fmt.sync ? rxSample
                      : (baudTick && rxSub_q == osr - 5'h01);
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rxState_q <= RX_IDLE;
            rxSub_q   <= 5'h00;
            rxCnt_q   <= 4'h0;
            rxShift_q <= 10'h000;
        end else if (!receive_enable_bit) begin
            rxState_q <= RX_IDLE;
        end else begin
            if (baudTick)
                rxSub_q <= (rxSub_q == osr - 5'h01) ? 5'h00 : rxSub_q + 5'h01;
            case (rxState_q)
                RX_IDLE: if (!rxLine_q) begin
                    rxState_q <= fmt.sync ? RX_DATA : RX_START;
                    rxSub_q   <= half; // Realign to mid-bit
                    rxCnt_q   <= 4'h0;
                    if (fmt.sync) rxState_q <= rxSample ? RX_DATA : RX_IDLE;
                end
                RX_START: if (rxMid)
                    rxState_q <= rxLine_q ? RX_IDLE : RX_DATA;
                RX_DATA: if (rxMid) begin
                    rxShift_q <= {rxLine_q, rxShift_q[9:1]};
                    rxCnt_q   <= rxCnt_q + 4'h1;
                    if (rxCnt_q + 4'h1 ==
                        fmt.nBits + {3'h0, fmt.parEn})
                        rxState_q <= RX_STOP;
                end
                RX_STOP: if (rxMid) rxState_q <= RX_IDLE;
                default: rxState_q <= RX_IDLE;
            endcase
        end
    end
    wire logic rxDone = receive_enable_bit && rxState_q == RX_STOP && rxMid;

    // Align shifted bits to LSB; drop parity bit
    logic [8:0] rxAligned;
    logic [9:0] rxWide;
    always_comb begin
        rxWide    = rxShift_q >> (4'hA - fmt.nBits - {3'h0, fmt.parEn});
        rxAligned = rxWide[8:0] & (9'h1FF >> (4'h9 - fmt.nBits));
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rxBuf_q  <= 9'h000;
            rxFull_q <= 1'b0;
        end else if (!receive_enable_bit) begin
            rxFull_q <= 1'b0;
        end else if (rxDone) begin
            rxBuf_q  <= rxAligned;
            rxFull_q <= 1'b1;
        end else if (rdData) begin
            rxFull_q <= 1'b0;
        end
    end
    assign serialInTaken = receive_enable_bit;

    // Control registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            statA_q <= RST_STAT_A;
            statB_q <= RST_STAT_B;
            frame_q <= RST_FRAME;
            baud_q  <= RST_BAUD;
        end else if (wr) begin
            case (paddr)
                ADDR_STAT_A: statA_q[BIT_DBL] <= pwdata[BIT_DBL];
                ADDR_STAT_B: statB_q <= pwdata[7:0];
                ADDR_FRAME:  frame_q <= pwdata[7:0];
                ADDR_BAUD:   baud_q  <= pwdata[11:0];
                default:     statA_q <= statA_q;
            endcase
        end
    end

    // Read data registered at the setup cycle
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) prdata <= 32'h0000_0000;
        else if (psel && !penable) begin
            case (paddr)
                ADDR_DATA:   prdata <= {24'h0, rxBuf_q[7:0]};
                ADDR_STAT_A: prdata <= {24'h0, rxFull_q, txDone_q, !txFull_q,
                                        3'h0, statA_q[BIT_DBL], 1'b0};
                ADDR_STAT_B: prdata <= {24'h0, statB_q[7:2], rxBuf_q[8],
                                        statB_q[BIT_TX_NINTH]};
                ADDR_FRAME:  prdata <= {24'h0, frame_q};
                ADDR_BAUD:   prdata <= {20'h0, baud_q};
                default:     prdata <= 32'h0000_0000;
            endcase
        end
    end

    // Interrupt requests
    assign txEmptyIrq    = globalIrqEnable && statB_q[BIT_TX_EMPTY_IE]
                           && !txFull_q;
    assign txCompleteIrq = globalIrqEnable && statB_q[BIT_TX_DONE_IE]
                           && txDone_q;
    assign rxCompleteIrq = globalIrqEnable && statB_q[BIT_RX_DONE_IE]
                           && rxFull_q;

endmodule : usd_usart

/* rtl/usd_pkg.sv */
package usd_pkg;

    // Register byte addresses on APB
    localparam logic [7:0] ADDR_DATA   = 8'h00;
    localparam logic [7:0] ADDR_STAT_A = 8'h04;
    localparam logic [7:0] ADDR_STAT_B = 8'h08;
    localparam logic [7:0] ADDR_FRAME  = 8'h0C;
    localparam logic [7:0] ADDR_BAUD   = 8'h10;

    // status_control_a bit positions
    localparam int BIT_RX_DONE     = 7;
    localparam int BIT_TX_DONE     = 6;
    localparam int BIT_TX_EMPTY    = 5;
    localparam int BIT_DBL         = 1;
    // status_control_b bit positions
    localparam int BIT_RX_DONE_IE  = 7;
    localparam int BIT_TX_DONE_IE  = 6;
    localparam int BIT_TX_EMPTY_IE = 5;
    localparam int BIT_RX_ON       = 4;
    localparam int BIT_TX_ON       = 3;
    localparam int BIT_CSZ2        = 2;
    localparam int BIT_RX_NINTH    = 1;
    localparam int BIT_TX_NINTH    = 0;
    // frame_config_reg bit positions
    localparam int BIT_SYNC  = 6;
    localparam int BIT_PEN   = 5;
    localparam int BIT_PODD  = 4;
    localparam int BIT_STOP2 = 3;
    localparam int BIT_CSZ1  = 2;
    localparam int BIT_CSZ0  = 1;
    localparam int BIT_CPOL  = 0;

    // Reset values
    localparam logic [7:0]  RST_STAT_A = 8'h20;
    localparam logic [7:0]  RST_STAT_B = 8'h00;
    localparam logic [7:0]  RST_FRAME  = 8'h06;
    localparam logic [11:0] RST_BAUD   = 12'h000;

    localparam logic [2:0] CSZ_NINE    = 3'h7;
    localparam logic [4:0] OSR_NORMAL  = 5'h10;
    localparam logic [4:0] OSR_DOUBLE  = 5'h08;

    typedef enum logic [2:0] {
        TX_IDLE   = 3'b000,
        TX_START  = 3'b001,
        TX_DATA   = 3'b010,
        TX_PARITY = 3'b011,
        TX_STOP   = 3'b100
    } usd_tx_state_t;

    typedef enum logic [1:0] {
        RX_IDLE  = 2'b00,
        RX_START = 2'b01,
        RX_DATA  = 2'b10,
        RX_STOP  = 2'b11
    } usd_rx_state_t;

    // Frame format as seen by both shifters
    typedef struct packed {
        logic       sync;
        logic       parEn;
        logic       parOdd;
        logic       stop2;
        logic [3:0] nBits;
        logic       cpol;
    } usd_fmt_t;

endpackage : usd_pkg

/* bench/usd_usart_properties.sv */
`timescale 1ns/1ps
module usd_usart_properties
    import usd_pkg::*;
(
    // Clock and reset
    input wire logic        clk,
    input wire logic        resetn,
    // Register bus
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    // Interrupts
    input wire logic        globalIrqEnable,
    input wire logic        txDoneAck,
    input wire logic        txEmptyIrq,
    input wire logic        txCompleteIrq,
    input wire logic        rxCompleteIrq,
    // Serial pins
    input wire logic        serialOut,
    input wire logic        serialOutEn,
    input wire logic        serialClockEn,
    input wire logic        serialInTaken
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    wire apbAcc = psel && penable;
    // At divisor 0 the sync clock toggles every clock and never passes the pin filter, so width checks skip sync mode
    wire asyncTx = serialOutEn && !serialClockEn;

    irq_gate_a: assert property (
        !globalIrqEnable |-> !(txEmptyIrq || txCompleteIrq || rxCompleteIrq)
    ) else $error("interrupt raised while globally masked");
    data_write_a: assert property (
        apbAcc && pwrite && paddr == ADDR_DATA |=> !txEmptyIrq
    ) else $error("buffer empty still flagged after data write");
    tx_take_a: assert property (
        apbAcc && pwrite && paddr == ADDR_STAT_B && pwdata[BIT_TX_ON]
        |=> serialOutEn
    ) else $error("output pin not taken after transmit enable");
    rx_take_a: assert property (
        apbAcc && pwrite && paddr == ADDR_STAT_B
        |=> serialInTaken == $past(pwdata[BIT_RX_ON])
    ) else $error("input pin ownership differs from receive enable");
    release_idle_a: assert property (
        $fell(serialOutEn) |-> serialOut
    ) else $error("output pin released in mid frame");
    low_width_a: assert property (
        asyncTx && $fell(serialOut) |-> !serialOut [*8]
    ) else $error("low bit shorter than eight clocks");
    high_width_a: assert property (
        asyncTx && $rose(serialOut) |-> serialOut [*8]
    ) else $error("high bit shorter than eight clocks");
    txc_ack_a: assert property (
        txDoneAck |=> !txCompleteIrq
    ) else $error("complete interrupt survives service");
    rx_read_a: assert property (
        apbAcc && !pwrite && paddr == ADDR_DATA |=> !rxCompleteIrq
    ) else $error("receive interrupt survives data read");
    clock_take_a: assert property (
        serialClockEn |-> serialOutEn || serialInTaken
    ) else $error("clock pin taken with both directions off");
    refuse_a: assert property (
        apbAcc && paddr > ADDR_BAUD |-> pslverr && prdata == 32'h0
    ) else $error("unmapped access not refused");

    cover property (asyncTx && $fell(serialOut));
    cover property ($rose(rxCompleteIrq));
    cover property (txDoneAck && txCompleteIrq);
    cover property (apbAcc && pslverr);
endmodule : usd_usart_properties

/* bench/usd_peer.sv */
`timescale 1ns/1ps
module usd_peer (
    // Clock
    input wire logic clk,
    // Line pair
    input wire logic txLine,
    output logic     rxLine
);
    initial rxLine = 1'b1;

    // Caller packs start, data LSB first and stop bits
    task automatic sendBits(input logic [11:0] v, input int n,
                            input int per);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            rxLine <= v[i];
            repeat (per - 1) @(posedge clk);
        end
        @(posedge clk);
        rxLine <= 1'b1;
    endtask : sendBits

    // Samples mid-bit; returns before the next start edge
    task automatic recvBits(output logic [11:0] v, input int n,
                            input int per);
        v = '0;
        @(negedge txLine);
        repeat (per / 2) @(posedge clk);
        for (int i = 0; i < n; i++) begin
            if (i > 0) begin
                repeat (per) @(posedge clk);
            end
            v[i] = txLine;
        end
    endtask : recvBits
endmodule : usd_peer

/* bench/usd_usart_tb_top.sv */
`timescale 1ns/1ps
module usd_usart_tb_top import usd_pkg::*; ;
    logic        clk, resetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rdData;
    logic        rdErr, globalIrqEnable, txDoneAck, serialIn;
    logic        txEmptyIrq, txCompleteIrq, rxCompleteIrq, serialOut;
    logic        serialOutEn, serialClockOut, serialClockEn, serialInTaken;
    int          n_mismatch, compares, cycles;
    // Released pin idles high through its pull-up
    wire         txPin = serialOutEn ? serialOut : 1'b1;

    usd_usart usd_usart_inst (
        .clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .globalIrqEnable(globalIrqEnable), .txDoneAck(txDoneAck),
        .txEmptyIrq(txEmptyIrq), .txCompleteIrq(txCompleteIrq),
        .rxCompleteIrq(rxCompleteIrq), .serialOut(serialOut),
        .serialOutEn(serialOutEn), .serialIn(serialIn),
        .serialClockIn(serialClockOut), .serialClockOut(serialClockOut),
        .serialClockEn(serialClockEn), .serialInTaken(serialInTaken)
    );
    usd_peer usd_peer_inst (.clk(clk), .txLine(txPin), .rxLine(serialIn));

    task automatic chk(input string name, input logic [31:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        logic rdy;
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            rdy    = pready;
            rdData = prdata;
            rdErr  = pslverr;
        end while (rdy !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic t_regs();
        logic [7:0]  a[5] = '{ADDR_STAT_A, ADDR_STAT_B, ADDR_FRAME,
                              ADDR_BAUD, 8'h20};
        logic [31:0] e[5] = '{{24'h0, RST_STAT_A}, {24'h0, RST_STAT_B},
                              {24'h0, RST_FRAME}, {20'h0, RST_BAUD}, 32'h0};
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, a[i], 32'h0);
            chk("regRead", rdData, e[i]);
            chk("slvErr", rdErr, 1'(i == 4));
            chk("ready", pready, 1'b1);
        end
    endtask : t_regs

    task automatic t_tx8();
        logic [11:0] f1, f2;
        apb(1'b1, ADDR_STAT_B, 32'h08);
        @(negedge clk);
        chk("outEn", serialOutEn, 1'b1);
        fork
            begin
                usd_peer_inst.recvBits(f1, 10, 16);
                usd_peer_inst.recvBits(f2, 10, 16);
            end
            begin
                apb(1'b1, ADDR_DATA, 32'hA5);
                // Second byte only once the first has left the buffer
                do apb(1'b0, ADDR_STAT_A, 32'h0);
                while (rdData[BIT_TX_EMPTY] !== 1'b1);
                apb(1'b1, ADDR_DATA, 32'h3C);
                apb(1'b0, ADDR_STAT_A, 32'h0);
                chk("bufEmpty", rdData[BIT_TX_EMPTY], 1'b0);
            end
        join
        chk("frame1", f1, {3'b001, 8'hA5, 1'b0});
        chk("frame2", f2, {3'b001, 8'h3C, 1'b0});
        repeat (12) @(posedge clk);
        apb(1'b0, ADDR_STAT_A, 32'h0);
        chk("txDone", rdData, 32'h60);
        apb(1'b1, ADDR_STAT_A, 32'h40);
        apb(1'b0, ADDR_STAT_A, 32'h0);
        chk("doneClear", rdData, 32'h20);
    endtask : t_tx8

    task automatic t_par();
        logic [11:0] f;
        for (int odd = 0; odd < 2; odd++) begin
            apb(1'b1, ADDR_FRAME, {26'h0, 1'b1, odd[0], 4'h4});
            fork
                usd_peer_inst.recvBits(f, 10, 16);
                apb(1'b1, ADDR_DATA, 32'hFF);
            join
            chk("parFrame", f, {2'b01, ^7'h7F ^ odd[0], 7'h7F, 1'b0});
            repeat (12) @(posedge clk);
        end
    endtask : t_par

    task automatic t_tx9();
        logic [11:0] f;
        apb(1'b1, ADDR_FRAME, 32'h06);
        apb(1'b1, ADDR_STAT_B, 32'h0D);
        fork
            usd_peer_inst.recvBits(f, 11, 16);
            begin
                apb(1'b1, ADDR_DATA, 32'h00);
                apb(1'b1, ADDR_STAT_B, 32'h04);
                @(negedge clk);
                chk("holdEn", serialOutEn, 1'b1);
            end
        join
        chk("ninth", f, {3'b011, 8'h00, 1'b0});
        repeat (12) @(negedge clk);
        chk("release", serialOutEn, 1'b0);
    endtask : t_tx9

    task automatic rx_one(input logic [31:0] fmt, input logic [11:0] v,
                          input int n, input logic [31:0] exp);
        apb(1'b1, ADDR_FRAME, fmt);
        usd_peer_inst.sendBits(v, n, 16);
        // Short bound: a wait for a second stop bit would overrun it
        repeat (8) if (rxCompleteIrq !== 1'b1) @(posedge clk);
        @(negedge clk);
        chk("rxIrq", rxCompleteIrq, 1'b1);
        apb(1'b0, ADDR_DATA, 32'h0);
        chk("rxData", rdData, exp);
        @(negedge clk);
        chk("rxIrqClr", rxCompleteIrq, 1'b0);
    endtask : rx_one

    task automatic t_irq();
        apb(1'b1, ADDR_FRAME, 32'h06);
        apb(1'b1, ADDR_STAT_A, 32'h40);
        apb(1'b1, ADDR_STAT_B, 32'h28);
        @(negedge clk);
        chk("emptyIrq", txEmptyIrq, 1'b1);
        @(posedge clk);
        globalIrqEnable <= 1'b0;
        @(negedge clk);
        chk("emptyMask", txEmptyIrq, 1'b0);
        @(posedge clk);
        globalIrqEnable <= 1'b1;
        apb(1'b1, ADDR_STAT_B, 32'h48);
        @(negedge clk);
        chk("emptyOff", txEmptyIrq, 1'b0);
        chk("doneIdle", txCompleteIrq, 1'b0);
        apb(1'b1, ADDR_DATA, 32'h55);
        repeat (400) if (txCompleteIrq !== 1'b1) @(posedge clk);
        @(negedge clk);
        chk("doneIrq", txCompleteIrq, 1'b1);
        @(posedge clk);
        txDoneAck <= 1'b1;
        @(posedge clk);
        txDoneAck <= 1'b0;
        @(negedge clk);
        chk("doneAck", txCompleteIrq, 1'b0);
    endtask : t_irq

    task automatic t_sync();
        logic v;
        apb(1'b1, ADDR_FRAME, 32'h46);
        apb(1'b1, ADDR_STAT_B, 32'h10);
        @(negedge clk);
        chk("clkEnRx", serialClockEn, 1'b1);
        chk("inTaken", serialInTaken, 1'b1);
        v = serialClockOut;
        @(negedge clk);
        chk("clkOut", serialClockOut, !v);
        apb(1'b1, ADDR_STAT_B, 32'h08);
        @(negedge clk);
        chk("clkEnTx", serialClockEn, 1'b1);
        apb(1'b1, ADDR_STAT_B, 32'h00);
        @(negedge clk);
        chk("clkEnOff", serialClockEn, 1'b0);
    endtask : t_sync

    task automatic summarize();
        $display("Comparisons %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : summarize

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Whole run needs about 1500 clocks
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            n_mismatch++;
            summarize();
        end
    end

    initial begin
        {psel, penable, pwrite, txDoneAck} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        globalIrqEnable = 1'b1;
        resetn = 1'b0;
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        t_regs();
        t_tx8();
        t_par();
        t_tx9();
        apb(1'b1, ADDR_STAT_B, 32'h90);
        rx_one(32'h06, {3'b001, 8'h5A, 1'b0}, 10, 32'h5A);
        rx_one(32'h0A, {5'b00001, 6'h2D, 1'b0}, 8, 32'h2D);
        t_irq();
        t_sync();
        summarize();
    end
endmodule : usd_usart_tb_top

bind usd_usart usd_usart_properties usd_usart_properties_inst (
    .clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pslverr(pslverr), .globalIrqEnable(globalIrqEnable),
    .txDoneAck(txDoneAck), .txEmptyIrq(txEmptyIrq),
    .txCompleteIrq(txCompleteIrq), .rxCompleteIrq(rxCompleteIrq),
    .serialOut(serialOut), .serialOutEn(serialOutEn),
    .serialClockEn(serialClockEn), .serialInTaken(serialInTaken)
);
